// >>> core/acl_pkg.sv
// What this block does
// - Host reaches table only via indirect registers
// - Sixteen rule entries kept per port
// - Five tables, one per switch port
// - Host updates one byte per command, read-modify-write
// - Entry read: two control writes, three reads
// - Entry write: one control read, three writes
// - Control select low nibble is address 11:8
// - Offset register is indirect address 7:0
// - Offsets 0x00-0x0D map bytes 15 downward
// - Offsets 0x0E and 0x0F are reserved
// - Offsets 0x10, 0x11 hold byte-enable masks
// - Offset 0x12 is entry control/status byte
// - Bits 7:5 equal 010 select rule table
// - Selected byte moves through data register
// - Control bit 4 set read, clear write
// - Offset register write triggers the access
package acl_pkg;
  // ----------------------------------------
  // Direct register offsets
  // ----------------------------------------
  localparam logic [7:0] ACL_OFF_CTL = 8'h6E;
  localparam logic [7:0] ACL_OFF_TRIG = 8'h6F;
  localparam logic [7:0] ACL_OFF_DATA = 8'hA0;
  localparam logic [7:0] ACL_CTL_RST = 8'h00;
  localparam logic [7:0] ACL_OFF_RST = 8'h00;
  localparam logic [7:0] ACL_DATA_RST = 8'h00;
  // ----------------------------------------
  // Control select fields
  // ----------------------------------------
  localparam int ACL_SEL_MSB = 7;
  localparam int ACL_SEL_LSB = 5;
  localparam int ACL_DIR_BIT = 4;
  localparam logic [2:0] ACL_SEL_RULE = 3'h2;
  // ----------------------------------------
  // Table geometry and indirect offsets
  // ----------------------------------------
  localparam int ACL_NPORT = 5;
  localparam int ACL_NENT = 16;
  localparam int ACL_SLOTS = 16;
  localparam int ACL_DEPTH = 1280;
  localparam logic [3:0] ACL_PORT_FIRST = 4'h1;
  localparam logic [3:0] ACL_PORT_LAST = 4'h5;
  localparam logic [7:0] ACL_IX_LAST_BYTE = 8'h0D;
  localparam logic [7:0] ACL_IX_RSV_END = 8'h0F;
  localparam logic [7:0] ACL_IX_BE_HI = 8'h10;
  localparam logic [7:0] ACL_IX_BE_LO = 8'h11;
  localparam logic [7:0] ACL_IX_STAT = 8'h12;
  localparam logic [3:0] ACL_SLOT_BE_HI = 4'hE;
  localparam logic [3:0] ACL_SLOT_BE_LO = 4'hF;
  localparam logic [7:0] ACL_BYTE_RST = 8'h00;
endpackage

// >>> core/acl_mgmt_if.sv
`timescale 1ns/1ps
// ----------------------------------------
// Byte register port between host and switch
// ----------------------------------------
interface acl_mgmt_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  modport dev (input wr, input rd, input addr, input wdata,
    output rdata, output rvalid);
  modport host (output wr, output rd, output addr, output wdata,
    input rdata, input rvalid);
endinterface

// >>> core/acl_dev.sv
`timescale 1ns/1ps
module acl_dev (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  acl_mgmt_if.dev bus,
  // Status
  output logic wr_pending
);
  // ----------------------------------------
  // Direct registers and table storage
  // ----------------------------------------
  logic [7:0] ctl_q;
  logic [7:0] off_q;
  logic [7:0] data_q;
  logic wpend_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [7:0] mem_q [0:acl_pkg::ACL_DEPTH-1];
  logic [3:0] esel_q [0:acl_pkg::ACL_NPORT-1];

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_ctl = bus.wr && bus.addr == acl_pkg::ACL_OFF_CTL;
  wire wr_trig = bus.wr && bus.addr == acl_pkg::ACL_OFF_TRIG;
  wire wr_data = bus.wr && bus.addr == acl_pkg::ACL_OFF_DATA;
  // Table chosen only by the 010 selector; others are not served here
  wire sel_rule = ctl_q[acl_pkg::ACL_SEL_MSB:acl_pkg::ACL_SEL_LSB]
    == acl_pkg::ACL_SEL_RULE;
  wire dir_rd = ctl_q[acl_pkg::ACL_DIR_BIT];
  wire [3:0] port_n = ctl_q[3:0];
  wire port_ok = port_n >= acl_pkg::ACL_PORT_FIRST &&
    port_n <= acl_pkg::ACL_PORT_LAST;
  wire [2:0] pidx = 3'(port_n - acl_pkg::ACL_PORT_FIRST);
  wire acc_ok = sel_rule && port_ok;

  // Offset used for lookup: the new one on a trigger, else the held one
  wire [7:0] ix = wr_trig ? bus.wdata : off_q;
  wire ix_byte = ix <= acl_pkg::ACL_IX_LAST_BYTE;
  wire ix_be = ix == acl_pkg::ACL_IX_BE_HI ||
    ix == acl_pkg::ACL_IX_BE_LO;
  wire ix_stat = ix == acl_pkg::ACL_IX_STAT;
  // Reserved 0x0E/0x0F slots reused internally for the byte enables
  wire [3:0] slot = ix_be ? (ix == acl_pkg::ACL_IX_BE_HI ?
    acl_pkg::ACL_SLOT_BE_HI : acl_pkg::ACL_SLOT_BE_LO) : ix[3:0];
  wire [3:0] ent = port_ok ? esel_q[pidx] : 4'h0;
  wire [10:0] midx = {pidx, ent, slot};
  wire [7:0] mem_rd = mem_q[port_ok ? midx : 11'h000];
  // Reserved and unmapped offsets read as zero
  wire [7:0] fetch = !acc_ok ? 8'h00 :
    (ix_byte || ix_be) ? mem_rd :
    ix_stat ? {4'h0, ent} : 8'h00;

  // ----------------------------------------
  // Direct registers and trigger
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_q <= acl_pkg::ACL_CTL_RST;
      off_q <= acl_pkg::ACL_OFF_RST;
      data_q <= acl_pkg::ACL_DATA_RST;
      wpend_q <= 1'b0;
    end else begin
      if (wr_ctl) begin
        ctl_q <= bus.wdata;
      end
      if (wr_trig) begin
        off_q <= bus.wdata;
        // Read loads byte now; write waits for the data byte
        wpend_q <= acc_ok && !dir_rd;
        if (acc_ok && dir_rd) begin
          data_q <= fetch;
        end
      end else if (wr_data) begin
        data_q <= bus.wdata;
        // Data byte consumes the armed write; a repeat does not store again
        wpend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Table storage commit on data write
  // ----------------------------------------
  wire commit = wr_data && wpend_q && !wr_trig && acc_ok &&
    (ix_byte || ix_be);
  wire stat_wr = wr_data && wpend_q && !wr_trig && acc_ok &&
    ix_stat;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < acl_pkg::ACL_DEPTH; i++) begin
        mem_q[i] <= acl_pkg::ACL_BYTE_RST;
      end
    end else if (commit) begin
      mem_q[midx] <= bus.wdata;
    end
  end

  // Entry select per port, lives in the status byte
  generate
    for (genvar p = 0; p < acl_pkg::ACL_NPORT; p++) begin : g_esel
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          esel_q[p] <= 4'h0;
        end else if (stat_wr && pidx == 3'(p)) begin
          esel_q[p] <= bus.wdata[3:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read answer, one cycle after the strobe
  // ----------------------------------------
  wire [7:0] rd_mux = bus.addr == acl_pkg::ACL_OFF_CTL ? ctl_q :
    bus.addr == acl_pkg::ACL_OFF_TRIG ? off_q :
    bus.addr == acl_pkg::ACL_OFF_DATA ? data_q : 8'h00;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus.rd;
      if (bus.rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.rvalid = rvalid_q;
  assign wr_pending = wpend_q;
endmodule // acl_dev

// >>> core/acl_host.sv
`timescale 1ns/1ps
module acl_host (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  acl_mgmt_if.host bus,
  // User command
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [3:0] cmd_port,
  input wire logic [7:0] cmd_offset,
  input wire logic [7:0] cmd_wdata,
  // User answer
  output logic cmd_ready,
  output logic cmd_done,
  output logic [7:0] cmd_rdata
);
  typedef enum logic [2:0] {
    ACL_H_IDLE = 3'b000,
    ACL_H_RCTL = 3'b001,
    ACL_H_WCTL = 3'b010,
    ACL_H_WOFF = 3'b011,
    ACL_H_ROFF = 3'b100,
    ACL_H_DATA = 3'b101
  } acl_hst_t;

  acl_hst_t st_q;
  logic wr_q, rd_q, pend_q, isw_q, ready_q, done_q;
  logic [7:0] addr_q, wdata_q, rdata_q, ctl_q, off_q, dat_q;

  // Control byte: table selector, direction, port
  wire [7:0] ctl_val = {acl_pkg::ACL_SEL_RULE, !isw_q,
    ctl_q[3:0]};

  // ----------------------------------------
  // Sequencer: one register access per state
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ACL_H_IDLE;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      pend_q <= 1'b0;
      isw_q <= 1'b0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      ctl_q <= 8'h00;
      off_q <= 8'h00;
      dat_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      done_q <= 1'b0;
      unique case (st_q)
        ACL_H_IDLE: begin
          ready_q <= 1'b1;
          if (cmd_valid && ready_q) begin
            ready_q <= 1'b0;
            isw_q <= cmd_write;
            ctl_q <= {4'h0, cmd_port};
            off_q <= cmd_offset;
            dat_q <= cmd_wdata;
            pend_q <= 1'b0;
            // Write starts with a control read, read with writes
            st_q <= cmd_write ? ACL_H_RCTL : ACL_H_WCTL;
          end
        end
        ACL_H_RCTL: begin
          if (!pend_q) begin
            rd_q <= 1'b1;
            addr_q <= acl_pkg::ACL_OFF_CTL;
            pend_q <= 1'b1;
          end else if (bus.rvalid) begin
            pend_q <= 1'b0;
            st_q <= isw_q ? ACL_H_WCTL : ACL_H_ROFF;
          end
        end
        ACL_H_WCTL: begin
          wr_q <= 1'b1;
          addr_q <= acl_pkg::ACL_OFF_CTL;
          wdata_q <= ctl_val;
          st_q <= ACL_H_WOFF;
        end
        ACL_H_WOFF: begin
          wr_q <= 1'b1;
          addr_q <= acl_pkg::ACL_OFF_TRIG;
          wdata_q <= off_q;
          st_q <= isw_q ? ACL_H_DATA : ACL_H_RCTL;
        end
        ACL_H_ROFF: begin
          if (!pend_q) begin
            rd_q <= 1'b1;
            addr_q <= acl_pkg::ACL_OFF_TRIG;
            pend_q <= 1'b1;
          end else if (bus.rvalid) begin
            pend_q <= 1'b0;
            st_q <= ACL_H_DATA;
          end
        end
        ACL_H_DATA: begin
          if (isw_q) begin
            wr_q <= 1'b1;
            addr_q <= acl_pkg::ACL_OFF_DATA;
            wdata_q <= dat_q;
            done_q <= 1'b1;
            st_q <= ACL_H_IDLE;
          end else if (!pend_q) begin
            rd_q <= 1'b1;
            addr_q <= acl_pkg::ACL_OFF_DATA;
            pend_q <= 1'b1;
          end else if (bus.rvalid) begin
            rdata_q <= bus.rdata;
            done_q <= 1'b1;
            pend_q <= 1'b0;
            st_q <= ACL_H_IDLE;
          end
        end
      endcase
    end
  end

  assign bus.wr = wr_q;
  assign bus.rd = rd_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign cmd_ready = ready_q;
  assign cmd_done = done_q;
  assign cmd_rdata = rdata_q;
endmodule // acl_host

// >>> tb/acl_chk.sv
`timescale 1ns/1ps
module acl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // Status
  input wire logic wr_pending
);
  logic [7:0] ctl_q;
  logic [7:0] off_q;
  // --------------------------------
  // Shadow of the control bytes
  // --------------------------------
  // Legal table select and a storable offset
  wire ctl_ok = ctl_q[7:5] == 3'h2 && ctl_q[3:0] inside {[4'h1:4'h5]};
  wire off_ok = wdata <= 8'h12 && !(wdata inside {8'h0E, 8'h0F});
  // Tracks what the host last wrote, for read-back
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_q <= 8'h00;
      off_q <= 8'h00;
    end else if (wr) begin
      ctl_q <= (addr == 8'h6E) ? wdata : ctl_q;
      off_q <= (addr == 8'h6F) ? wdata : off_q;
    end
  end
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_trig;
    wr && addr == 8'h6F;
  endsequence
  sequence s_arm;
    wr && addr == 8'h6F && ctl_ok && !ctl_q[4] && off_ok;
  endsequence
  sequence s_data_wr;
    wr && addr == 8'hA0;
  endsequence
  AST_RD_ANSWER: assert property (rd |=> rvalid)
    else $error("no rvalid after read strobe");
  AST_RVALID_CAUSE: assert property (rvalid |-> $past(rd))
    else $error("rvalid without read strobe");
  AST_RDATA_HOLD: assert property (!rd |=> $stable(rdata))
    else $error("rdata moved without a read");
  AST_CTL_BACK: assert property (rd && addr == 8'h6E |=>
    rdata == $past(ctl_q)) else $error("select byte read-back wrong");
  AST_OFF_BACK: assert property (rd && addr == 8'h6F |=>
    rdata == $past(off_q)) else $error("offset byte read-back wrong");
  AST_ARM: assert property (s_arm |=> wr_pending)
    else $error("write trigger did not arm");
  AST_NOARM: assert property (s_trig ##0 (ctl_q[4] || !ctl_ok) |=>
    !wr_pending) else $error("read or refused trigger armed a write");
  AST_COMMIT: assert property (s_arm ##1 s_data_wr |=> !wr_pending)
    else $error("data write left access pending");
  AST_PEND_HOLD: assert property (wr_pending && !wr |=> wr_pending)
    else $error("pending write dropped by itself");
endmodule // acl_chk

// >>> tb/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
  n_fail++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module testbench;
  logic clk;
  logic resetn;
  logic cmd_valid;
  logic cmd_write;
  logic [3:0] cmd_port;
  logic [7:0] cmd_offset;
  logic [7:0] cmd_wdata;
  logic cmd_ready;
  logic cmd_done;
  logic [7:0] cmd_rdata;
  logic wr_pending;
  int n_fail;
  int tests_run;
  acl_mgmt_if bus_if ();
  acl_dev acl_dev_inst (.clk(clk), .resetn(resetn), .bus(bus_if),
    .wr_pending(wr_pending));
  acl_host acl_host_inst (.clk(clk), .resetn(resetn), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_port(cmd_port),
    .cmd_offset(cmd_offset), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .cmd_rdata(cmd_rdata));
  acl_chk acl_chk_inst (.clk(clk), .resetn(resetn), .wr(bus_if.wr),
    .rd(bus_if.rd), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .rdata(bus_if.rdata), .rvalid(bus_if.rvalid), .wr_pending(wr_pending));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // --------------------------------
  // Tasks
  // --------------------------------
  task give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One byte command; flags sampled at negedge to stay clear of updates
  task do_cmd(input logic w, input logic [3:0] p, input logic [7:0] o,
    input logic [7:0] d);
    int i;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 40) begin
      @(negedge clk);
      i++;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_port <= p;
    cmd_offset <= o;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (cmd_done !== 1'b1 && i < 40);
    if (cmd_done !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task rd_chk(input logic [3:0] p, input logic [7:0] o, input logic [7:0] e);
    do_cmd(1'b0, p, o, 8'h00);
    `CHK("cmd_rdata", e, cmd_rdata)
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    {cmd_valid, cmd_write, cmd_port, cmd_offset, cmd_wdata} = '0;
    n_fail = 0;
    tests_run = 0;
    resetn = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(4'h1, 8'h00, 8'h00);
    // Both ends of the byte range on every table
    for (int p = 1; p <= 5; p++) begin
      do_cmd(1'b1, 4'(p), 8'h00, {4'(p), 4'hA});
      do_cmd(1'b1, 4'(p), 8'h0D, {4'hC, 4'(p)});
    end
    for (int p = 1; p <= 5; p++) begin
      rd_chk(4'(p), 8'h00, {4'(p), 4'hA});
      rd_chk(4'(p), 8'h0D, {4'hC, 4'(p)});
    end
    do_cmd(1'b1, 4'h1, 8'h01, 8'h5B);
    rd_chk(4'h1, 8'h01, 8'h5B);
    rd_chk(4'h1, 8'h00, 8'h1A);
    // Reserved slots swallow writes
    do_cmd(1'b1, 4'h1, 8'h0E, 8'hFF);
    do_cmd(1'b1, 4'h1, 8'h0F, 8'hFF);
    rd_chk(4'h1, 8'h0E, 8'h00);
    rd_chk(4'h1, 8'h0F, 8'h00);
    do_cmd(1'b1, 4'h1, 8'h10, 8'h3C);
    do_cmd(1'b1, 4'h1, 8'h11, 8'hC3);
    rd_chk(4'h1, 8'h10, 8'h3C);
    rd_chk(4'h1, 8'h11, 8'hC3);
    // Last entry kept apart from entry 0
    do_cmd(1'b1, 4'h2, 8'h12, 8'h0F);
    rd_chk(4'h2, 8'h12, 8'h0F);
    do_cmd(1'b1, 4'h2, 8'h00, 8'h77);
    rd_chk(4'h2, 8'h00, 8'h77);
    do_cmd(1'b1, 4'h2, 8'h12, 8'h00);
    rd_chk(4'h2, 8'h00, 8'h2A);
    // Host-side read-modify-write of one byte keeps its neighbour
    rd_chk(4'h3, 8'h00, 8'h3A);
    do_cmd(1'b1, 4'h3, 8'h00, 8'h3A | 8'h01);
    rd_chk(4'h3, 8'h00, 8'h3B);
    rd_chk(4'h3, 8'h0D, 8'hC3);
    // Refused ports leave the data byte as last fetched
    rd_chk(4'h1, 8'h0D, 8'hC1);
    rd_chk(4'h6, 8'h00, 8'hC1);
    rd_chk(4'h0, 8'h00, 8'hC1);
    give_verdict();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule // testbench
